/* File: hdl/rcsc_pkg.sv */
// Package: constants for the reset and clock switch control block
`default_nettype none
package rcsc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_SYSCTL  = 4'h0;
  localparam logic [3:0] ADDR_TRAPCTL = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_ID      = 4'h3;
  // Fields of system_clock_ctrl_reg
  localparam int SYSCK_BIT = 5;
  localparam int XTEN_BIT  = 6;
  localparam int XEN_BIT   = 7;
  // Fields of the trap control register
  localparam int TRAP_RAM_SELECT_BIT  = 0;
  localparam int ATOUT_BIT = 1;
  localparam int WDTEN_BIT = 2;
  // Reset values
  // Fast oscillator only, so reset leaves the block in the first fast mode
  localparam logic [7:0] SYSCTL_RST  = 8'h80;
  localparam logic [7:0] TRAPCTL_RST = 8'h06;
  // Reset vector address
  localparam logic [15:0] RESET_VEC_LO = 16'hFFFE;
  localparam logic [15:0] RESET_VEC_HI = 16'hFFFF;
  // Stretch of a malfunction reset, in high clock periods
  localparam int MAL_RST_PERIODS = 24;
  // External reset: 12 high clock periods
  localparam int EXT_RST_PERIODS = 12;
  // Clock synchronisation wait on change back to fast clock
  localparam int SYNC_WAIT = 4;
  localparam logic [7:0] BLOCK_ID = 8'h5A;  // Arbitrary value
  typedef enum logic [1:0] {
    RCSC_FAST1 = 2'b00,
    RCSC_FAST2 = 2'b01,
    RCSC_LOW_SPEED_RUN_TWO = 2'b10,
    RCSC_LOW_SPEED_RUN_ONE = 2'b11
  } rcsc_mode_e;
  typedef enum logic [1:0] {
    RCSC_RUN   = 2'b00,
    RCSC_HOLD  = 2'b01,
    RCSC_VLO   = 2'b10,
    RCSC_VHI   = 2'b11
  } rcsc_rst_e;
endpackage
`default_nettype wire

/* File: hdl/rcsc_stretch.sv */
// Counter that stretches a combined malfunction reset request
`timescale 1ns/1ns
`default_nettype none
module rcsc_stretch
  import rcsc_pkg::*;
#(
  parameter int PERIODS = MAL_RST_PERIODS
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic req,
  output logic      active
);
  localparam int CW = $clog2(PERIODS + 1);
  logic [CW-1:0] cnt_q;

  if (PERIODS < 1) begin : g_bad_periods
    $error("PERIODS must be at least one");
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (req) begin
      cnt_q <= CW'(PERIODS);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign active = (cnt_q != '0);
endmodule
`default_nettype wire

/* File: hdl/rcsc_top.sv */
// Reset generation and system clock switch control
// Notes on behaviour
// - After selecting fast clock, run on slow clock until clocks align.
// - Reset pin low ends slow mode; restart in first fast mode.
// - Four reset sources; trap, watchdog and clock resets are malfunction.
// - Malfunction reset holds internal reset at least 24 fast periods.
// - Malfunction counter cleared by rstn; no spurious short reset at power-up.
// - Reset clears interrupt enables and latches; PC from reset vector.
// - Reset clears prescaler and divider, and enables the watchdog.
// - Pin low for 12 fast periods applies an external reset.
// - Pin release starts execution at the two-byte reset vector.
// - Fetch from register, debug or trap-selected RAM area traps.
// - Trap response selects reset or interrupt; RAM area selectable.
// - Release reads reset vector, then fetches at its address.
// - Clock reset on illegal oscillator enable clears.
// - Oscillators keep running during a clock reset.
// - Leaving stop mode clears prescaler and divider.
`timescale 1ns/1ns
`default_nettype none
module rcsc_top
  import rcsc_pkg::*;
#(
  parameter int EXT_PERIODS = EXT_RST_PERIODS,
  parameter int DIV_W       = 8
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        reset_pin_n,
  input  wire logic        wdt_req,
  input  wire logic        stop_release,
  input  wire logic        fetch_valid,
  input  wire logic        fetch_sfr,
  input  wire logic        fetch_dbr,
  input  wire logic        fetch_ram,
  input  wire logic        clocks_aligned,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  output logic             core_rst_n,
  output logic             vec_fetch,
  output logic      [15:0] vec_addr,
  output logic             irq_clear,
  output logic             trap_irq,
  output logic             high_osc_en,
  output logic             low_osc_en,
  output logic             use_low_clock,
  output logic             wdt_enable,
  output logic      [DIV_W-1:0] divider
);
  localparam int EW = $clog2(EXT_PERIODS + 1);

  if (EXT_PERIODS < 1) begin : g_bad_ext
    $error("EXT_PERIODS must be at least one");
  end
  if (DIV_W < 2) begin : g_bad_div
    $error("DIV_W must be at least two");
  end

  logic [7:0]        sysctl_q;
  logic [7:0]        trapctl_q;
  logic [EW-1:0]     ext_cnt_q;
  logic              ext_rst_q;
  logic              mal_req;
  logic              mal_active;
  logic              clk_rst_req;
  logic              trap_hit;
  logic              internal_rst;
  logic [2:0]        sync_q;
  logic              sel_low_q;
  rcsc_mode_e        mode_q;
  rcsc_rst_e         rst_q;
  logic              wr_sys;
  logic [7:0]        sys_new;

  assign wr_sys  = wr && (addr == ADDR_SYSCTL);
  assign sys_new = wdata;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_cnt_q <= '0;
      ext_rst_q <= 1'b1;
    end else if (reset_pin_n) begin
      ext_cnt_q <= '0;
      ext_rst_q <= 1'b0;
    end else if (ext_cnt_q != EW'(EXT_PERIODS - 1)) begin
      ext_cnt_q <= ext_cnt_q + 1'b1;
    end else begin
      ext_rst_q <= 1'b1;
    end
  end

  always_comb begin
    clk_rst_req = 1'b0;
    if (wr_sys) begin
      if (!sys_new[XEN_BIT] && !sys_new[XTEN_BIT]) begin
        clk_rst_req = 1'b1;
      end else if (!sys_new[XEN_BIT] && !sysctl_q[SYSCK_BIT]
                   && !sys_new[SYSCK_BIT]) begin
        clk_rst_req = 1'b1;
      end else if (!sys_new[XTEN_BIT] && sysctl_q[SYSCK_BIT]
                   && sys_new[SYSCK_BIT]) begin
        clk_rst_req = 1'b1;
      end
    end
  end

  assign trap_hit = fetch_valid && (fetch_sfr || fetch_dbr
                    || (fetch_ram && trapctl_q[TRAP_RAM_SELECT_BIT]));

  // Trap as reset only when selected
  assign mal_req = (trap_hit && trapctl_q[ATOUT_BIT]) || wdt_req
                   || clk_rst_req;

  // Counter is left only under the async reset port
  rcsc_stretch #(
    .PERIODS (MAL_RST_PERIODS)
  ) u_stretch (
    .clock  (clock),
    .rstn   (rstn),
    .req    (mal_req),
    .active (mal_active)
  );

  assign internal_rst = ext_rst_q || mal_active;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trap_irq <= 1'b0;
    end else begin
      trap_irq <= trap_hit && !trapctl_q[ATOUT_BIT] && !internal_rst;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_rst_n <= 1'b0;
      irq_clear  <= 1'b1;
    end else begin
      core_rst_n <= !internal_rst;
      irq_clear  <= internal_rst;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_q     <= RCSC_HOLD;
      vec_fetch <= 1'b0;
      vec_addr  <= RESET_VEC_LO;
    end else if (internal_rst) begin
      rst_q     <= RCSC_HOLD;
      vec_fetch <= 1'b0;
      vec_addr  <= RESET_VEC_LO;
    end else begin
      unique case (rst_q)
        RCSC_HOLD: begin
          rst_q     <= RCSC_VLO;
          vec_fetch <= 1'b1;
          vec_addr  <= RESET_VEC_LO;
        end
        RCSC_VLO: begin
          rst_q     <= RCSC_VHI;
          vec_fetch <= 1'b1;
          vec_addr  <= RESET_VEC_HI;
        end
        RCSC_VHI: begin
          rst_q     <= RCSC_RUN;
          vec_fetch <= 1'b0;
        end
        RCSC_RUN: begin
          vec_fetch <= 1'b0;
        end
      endcase
    end
  end

  // Clock reset keeps both oscillators on
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sysctl_q <= SYSCTL_RST;
    end else if (internal_rst || clk_rst_req) begin
      sysctl_q <= SYSCTL_RST;
    end else if (wr_sys) begin
      sysctl_q <= sys_new;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trapctl_q <= TRAPCTL_RST;
    end else if (internal_rst) begin
      trapctl_q <= TRAPCTL_RST;
    end else if (wr && addr == ADDR_TRAPCTL) begin
      trapctl_q <= wdata;
    end
  end

  // Stay on slow clock until aligned
  // Alignment needs SYNC_WAIT agreeing samples, hiding a glitchy change
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_low_q <= 1'b0;
      sync_q    <= '0;
    end else if (internal_rst) begin
      sel_low_q <= 1'b0;
      sync_q    <= '0;
    end else if (sysctl_q[SYSCK_BIT]) begin
      sel_low_q <= 1'b1;
      sync_q    <= '0;
    end else if (sel_low_q) begin
      if (!clocks_aligned) begin
        sync_q <= '0;
      end else if (sync_q == 3'(SYNC_WAIT - 1)) begin
        sel_low_q <= 1'b0;
        sync_q    <= '0;
      end else begin
        sync_q <= sync_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= RCSC_FAST1;
    end else if (internal_rst) begin
      mode_q <= RCSC_FAST1;
    end else if (sel_low_q) begin
      mode_q <= sysctl_q[XEN_BIT] ? RCSC_LOW_SPEED_RUN_TWO : RCSC_LOW_SPEED_RUN_ONE;
    end else begin
      mode_q <= sysctl_q[XTEN_BIT] ? RCSC_FAST2 : RCSC_FAST1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      divider <= '0;
    end else if (internal_rst || stop_release) begin
      divider <= '0;
    end else begin
      divider <= divider + 1'b1;
    end
  end

  // Oscillators held on
  // Both run while reset stretches, costing power, so no clock is lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      high_osc_en   <= 1'b1;
      low_osc_en    <= 1'b1;
      use_low_clock <= 1'b0;
      wdt_enable    <= 1'b1;
    end else begin
      high_osc_en   <= sysctl_q[XEN_BIT] || internal_rst;
      low_osc_en    <= sysctl_q[XTEN_BIT] || internal_rst;
      use_low_clock <= sel_low_q;
      wdt_enable    <= trapctl_q[WDTEN_BIT];
    end
  end

  // Read port; unmapped reads return zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        ADDR_SYSCTL:  rdata <= sysctl_q;
        ADDR_TRAPCTL: rdata <= trapctl_q;
        ADDR_STATUS:  rdata <= {4'h0, sel_low_q, mode_q, internal_rst};
        ADDR_ID:      rdata <= BLOCK_ID;
        default:      rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/rcsc_monitor.sv */
// Assertion checker for the reset and clock switch control block
`timescale 1ns/1ns
`default_nettype none
module rcsc_monitor
  import rcsc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic             clock,
  input wire logic             rstn,
  input wire logic             reset_pin_n,
  input wire logic             wdt_req,
  input wire logic             stop_release,
  input wire logic             clocks_aligned,
  input wire logic             core_rst_n,
  input wire logic             vec_fetch,
  input wire logic [15:0]      vec_addr,
  input wire logic             irq_clear,
  input wire logic             high_osc_en,
  input wire logic             low_osc_en,
  input wire logic             use_low_clock,
  input wire logic             wdt_enable,
  input wire logic [DIV_W-1:0] divider
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence pin_held_s;
    !reset_pin_n [*8] ##1 !reset_pin_n [*4];
  endsequence
  sequence vec_pair_s;
    vec_addr == RESET_VEC_LO ##1 vec_fetch && vec_addr == RESET_VEC_HI;
  endsequence
  // Second cycle of reset, so registered outputs have settled
  sequence in_rst_s;
    !core_rst_n ##1 !core_rst_n;
  endsequence
  pin_reset_a: assert property (pin_held_s |-> ##[1:2] !core_rst_n)
    else $error("long pin low gave no reset");
  vec_order_a: assert property (
    $rose(vec_fetch) |-> vec_pair_s ##1 !vec_fetch)
    else $error("vector fetch order wrong");
  mal_start_a: assert property (
    $rose(wdt_req) |-> ##[1:2] !core_rst_n)
    else $error("watchdog request gave no reset");
  mal_length_a: assert property (
    $fell(wdt_req) |-> ##[22:28] core_rst_n)
    else $error("malfunction reset too long");
  irq_clear_a: assert property (in_rst_s |-> irq_clear)
    else $error("interrupt state not cleared in reset");
  wdt_div_a: assert property (
    in_rst_s |-> wdt_enable && divider == '0)
    else $error("watchdog or divider wrong in reset");
  osc_run_a: assert property (
    in_rst_s |-> high_osc_en && low_osc_en && !use_low_clock)
    else $error("oscillator or clock select wrong in reset");
  div_clear_a: assert property (stop_release |=> divider == '0)
    else $error("divider not cleared on stop exit");
  slow_hold_a: assert property (
    use_low_clock && !clocks_aligned && core_rst_n && reset_pin_n
    && !wdt_req |=> use_low_clock)
    else $error("left slow clock before alignment");
endmodule
`default_nettype wire

/* File: tb/rcsc_pin_model.sv */
// Model of the external source that drives the reset pin
`timescale 1ns/1ns
`default_nettype none
module rcsc_pin_model (
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [4:0] len,
  output logic            reset_pin_n
);
  logic [4:0] left_q = '0;
  // pin held low for len edges; pull-up keeps it high otherwise
  always @(posedge clock) begin
    if (go) begin
      left_q <= len;
    end else if (left_q != '0) begin
      left_q <= left_q - 5'h1;
    end
  end
  assign reset_pin_n = (left_q == '0);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench for the reset and clock switch control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import rcsc_pkg::*;
  logic        clock, rstn, clocks_aligned, wr, rd, reset_pin_n;
  logic        core_rst_n, vec_fetch, irq_clear, trap_irq, wdt_enable;
  logic        high_osc_en, low_osc_en, use_low_clock;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, divider;
  logic [15:0] vec_addr;
  logic [6:0]  strobes;
  logic [4:0]  pin_len;
  wire logic   pin_go, stop_release, wdt_req, fetch_valid;
  wire logic   fetch_ram, fetch_dbr, fetch_sfr;
  int          mismatches, comparisons;
  logic [7:0]  ev [8] = '{8'h10, 8'h09, 8'h0A, 8'h0C,
                          8'h0C, 8'h09, 8'h40, 8'h40};
  logic [7:0]  tv [8] = '{8'h06, 8'h06, 8'h06, 8'h06,
                          8'h07, 8'h04, 8'h06, 8'h06};
  logic [7:0]  rs = 8'b1001_0111;
  logic [7:0]  pre [3] = '{8'hC0, 8'hC0, 8'hE0};
  logic [7:0]  bad [3] = '{8'h00, 8'h40, 8'hA0};
  assign {pin_go, stop_release, wdt_req, fetch_valid} = strobes[6:3];
  assign {fetch_ram, fetch_dbr, fetch_sfr} = strobes[2:0];
  rcsc_top u_rcsc_top (.*);
  rcsc_pin_model u_rcsc_pin_model (.clock, .go(pin_go), .len(pin_len),
    .reset_pin_n);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge clock);
    strobes <= v;
    @(posedge clock);
    strobes <= '0;
  endtask
  // Counts reset and trap interrupt cycles over a window past any stretch;
  // sampling starts just after the edge that samples the request, as the trap pulse is short
  task automatic observe(input logic exp_rst, input logic exp_irq);
    int low, irq;
    low = 0;
    irq = 0;
    repeat (40) begin
      #1 low += int'(!core_rst_n);
      irq += int'(trap_irq);
      @(posedge clock);
    end
    chk(low > 0, exp_rst);
    chk(low <= MAL_RST_PERIODS + 2, 1'b1);
    chk(irq, exp_irq);
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #20000 mismatches++;
    report_and_stop();
  end
  initial begin
    {rstn, wr, rd, addr, wdata, strobes, pin_len} = '0;
    clocks_aligned = 1'b1;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk({core_rst_n, irq_clear, wdt_enable}, 3'b101);
    rd_chk(ADDR_STATUS, 8'h00);
    wr_reg(4'hF, 8'h00);
    rd_chk(ADDR_SYSCTL, SYSCTL_RST);
    rd_chk(ADDR_TRAPCTL, TRAPCTL_RST);
    rd_chk(ADDR_ID, BLOCK_ID);
    pulse(7'h20);
    #1 chk(divider, 8'h00);
    wr_reg(ADDR_SYSCTL, 8'hC0);
    wr_reg(ADDR_SYSCTL, 8'hE0);
    @(posedge clock);
    rd_chk(ADDR_STATUS, 8'h0C);
    wr_reg(ADDR_SYSCTL, 8'h60);
    rd_chk(ADDR_STATUS, 8'h0E);
    chk(high_osc_en, 1'b0);
    wr_reg(ADDR_SYSCTL, 8'hE0);
    clocks_aligned <= 1'b0;
    wr_reg(ADDR_SYSCTL, 8'hC0);
    repeat (6) @(posedge clock);
    #1 chk(use_low_clock, 1'b1);
    clocks_aligned <= 1'b1;
    repeat (8) @(posedge clock);
    rd_chk(ADDR_STATUS, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_SYSCTL, pre[i]);
      wr_reg(ADDR_SYSCTL, bad[i]);
      observe(1'b1, 1'b0);
      rd_chk(ADDR_SYSCTL, SYSCTL_RST);
    end
    for (int i = 0; i < 8; i++) begin
      wr_reg(ADDR_TRAPCTL, tv[i]);
      pin_len <= 5'(EXT_RST_PERIODS + i - 7);
      pulse(ev[i][6:0]);
      observe(rs[i], i == 5);
    end
    report_and_stop();
  end
endmodule
bind rcsc_top rcsc_monitor #(.DIV_W(DIV_W)) u_rcsc_monitor (.*);
`default_nettype wire
